/* File: cdr_control_status_registers.sv */
// Control and status register bank of the clock and data recovery receiver
`timescale 1ns/1ps
module cdr_control_status_registers #(
  parameter logic [7:0] REVISION_VALUE = 8'h01,  // Arbitrary value
  parameter logic [7:0] DEVICE_VALUE   = 8'h02,  // Arbitrary value
  parameter logic [7:0] SIG_HIGH_VALUE = 8'h03,  // Arbitrary value
  parameter logic [7:0] SIG_LOW_VALUE  = 8'h04   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             rstn,
  // Register access port
  input  wire logic                             regWrite,
  input  wire logic                             regRead,
  input  wire logic [cdr_regs_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [cdr_regs_pkg::DATA_W-1:0]  regWdata,
  output logic      [cdr_regs_pkg::DATA_W-1:0]  regRdata,
  // Analog core status, asynchronous
  input  wire logic                             signalLossRaw,
  input  wire logic                             lockLostRaw,
  input  wire logic                             lossActionDoneRaw,
  // Rate measurement engine, same clock
  input  wire logic                             rateMeasureDone,
  // Test-pattern capture word, same clock
  input  wire logic [31:0]                      patternCaptureWord,
  // Controls to the core
  output logic      [2:0]                       recoveryModeSelect,
  output logic                                  rateMeasureStart,
  output logic                                  rateMeasureClear,
  output logic                                  softResetPulse,
  output logic                                  frequencyAcquireStart,
  output logic                                  lockIndicationStyle,
  output logic                                  signalLossPowerDown,
  output logic                                  refClockPowerDown,
  output logic                                  lockCheckSource,
  output logic      [1:0]                       refFreqBand,
  output logic      [3:0]                       rateRatioCode,
  output logic                                  clockRecoveryEnable,
  // Indicator pins
  output logic                                  signalLossPin,
  output logic                                  lockLostPin
);
  import cdr_regs_pkg::*;

  logic [7:0] modeCtrl;
  logic [7:0] resetCtrl;
  logic [7:0] refPwrCtrl;
  logic [7:0] refSetup;
  logic [2:0] lossSync;
  logic [2:0] lockSync;
  logic [2:0] doneSync;
  logic       signalLoss;
  logic       lockLost;
  logic       lossDone;
  logic       stickyLockLost;
  logic       rateComplete;
  logic [7:0] statusByte;
  logic [7:0] softResetCount;
  logic       wrMode;
  logic       wrReset;

  // Writes during a soft reset are ignored, strobes included
  assign wrMode  = regWrite && !softResetPulse && regAddr == OFS_MODE_CTRL;
  assign wrReset = regWrite && !softResetPulse && regAddr == OFS_RESET_CTRL;

  // Three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lossSync <= 3'h0;
      lockSync <= 3'h0;
      doneSync <= 3'h0;
    end else begin
      lossSync <= {lossSync[1:0], signalLossRaw};
      lockSync <= {lockSync[1:0], lockLostRaw};
      doneSync <= {doneSync[1:0], lossActionDoneRaw};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      signalLoss <= 1'b0;
      lockLost   <= 1'b0;
      lossDone   <= 1'b0;
    end else begin
      if (lossSync[1] == lossSync[2]) signalLoss <= lossSync[2] & ~signalLossPowerDown;
      if (lockSync[1] == lockSync[2]) lockLost <= lockSync[2];
      if (doneSync[1] == doneSync[2]) lossDone <= doneSync[2];
    end
  end

  // Control registers; self-clearing action bits are not stored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modeCtrl   <= RST_MODE_CTRL;
      resetCtrl  <= RST_RESET_CTRL;
      refPwrCtrl <= RST_REFPWR_CTRL;
      refSetup   <= RST_REF_SETUP;
    end else if (softResetPulse) begin
      modeCtrl   <= RST_MODE_CTRL;
      resetCtrl  <= RST_RESET_CTRL;
      refPwrCtrl <= RST_REFPWR_CTRL;
      refSetup   <= RST_REF_SETUP;
    end else if (regWrite) begin
      unique case (regAddr)
        OFS_MODE_CTRL:   modeCtrl   <= regWdata & MC_WRITE_MASK;
        OFS_RESET_CTRL:  resetCtrl  <= regWdata & RC_WRITE_MASK;
        OFS_REFPWR_CTRL: refPwrCtrl <= regWdata & PC_WRITE_MASK;
        OFS_REF_SETUP:   refSetup   <= regWdata & RS_WRITE_MASK;
        default: ;
      endcase
    end
  end

  // Pulses fire on the falling write of a 1-then-0 pair
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frequencyAcquireStart <= 1'b0;
      softResetCount        <= 8'h00;
    end else begin
      frequencyAcquireStart <= wrReset && resetCtrl[RC_ACQ_START] && !regWdata[RC_ACQ_START];
      if (wrReset && resetCtrl[RC_SOFT_RESET] && !regWdata[RC_SOFT_RESET])
        softResetCount <= 8'(SOFT_RESET_CYCLES);
      else if (softResetCount != 8'h00)
        softResetCount <= softResetCount - 8'h01;
    end
  end
  assign softResetPulse = softResetCount != 8'h00;

  // Measurement strobes, one cycle each
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rateMeasureStart <= 1'b0;
      rateMeasureClear <= 1'b0;
    end else begin
      rateMeasureStart <= wrMode && regWdata[MC_RATE_START];
      rateMeasureClear <= wrMode && regWdata[MC_RATE_CLEAR];
    end
  end

  // Sticky flags: a new event beats a simultaneous clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stickyLockLost <= 1'b0;
      rateComplete   <= 1'b0;
    end else begin
      if (lockLost) stickyLockLost <= 1'b1;
      else if (softResetPulse || (wrMode && regWdata[MC_STICKY_CLR])) stickyLockLost <= 1'b0;
      if (rateMeasureDone) rateComplete <= 1'b1;
      else if (softResetPulse || (wrMode && regWdata[MC_RATE_CLEAR])) rateComplete <= 1'b0;
    end
  end

  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_SIGNAL_LOSS] = signalLoss;
    statusByte[ST_LOCK_LOST]   = lockLost;
    statusByte[ST_LOSS_DONE]   = lossDone;
    statusByte[ST_STICKY_LOCK] = stickyLockLost;
    statusByte[ST_RATE_DONE]   = rateComplete;
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        OFS_STATUS:      regRdata <= statusByte;
        OFS_MODE_CTRL:   regRdata <= modeCtrl;
        OFS_RESET_CTRL:  regRdata <= resetCtrl;
        OFS_REFPWR_CTRL: regRdata <= refPwrCtrl;
        OFS_REF_SETUP:   regRdata <= refSetup;
        OFS_SIG_HIGH:    regRdata <= SIG_HIGH_VALUE;
        OFS_SIG_LOW:     regRdata <= SIG_LOW_VALUE;
        OFS_CAPTURE0:    regRdata <= patternCaptureWord[7:0];
        OFS_CAPTURE1:    regRdata <= patternCaptureWord[15:8];
        OFS_CAPTURE2:    regRdata <= patternCaptureWord[23:16];
        OFS_CAPTURE3:    regRdata <= patternCaptureWord[31:24];
        OFS_REVISION:    regRdata <= REVISION_VALUE;
        OFS_DEVICE:      regRdata <= DEVICE_VALUE;
        default:         regRdata <= 8'h00;
      endcase
    end
  end

  assign recoveryModeSelect  = modeCtrl[MC_MODE_LSB +: 3];
  assign lockIndicationStyle = resetCtrl[RC_LOCK_STYLE];
  assign signalLossPowerDown = resetCtrl[RC_LOSS_PDN];
  assign refClockPowerDown   = refPwrCtrl[PC_REF_PDN];
  assign lockCheckSource     = refSetup[RS_CHECK_SRC];
  assign refFreqBand         = refSetup[RS_BAND_LSB +: 2];
  assign rateRatioCode       = refSetup[RS_RATIO_LSB +: 4];
  assign clockRecoveryEnable = 1'b1;

  // Pins from flops so polarity changes stay glitch free
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      signalLossPin <= 1'b0;
      lockLostPin   <= 1'b0;
    end else begin
      signalLossPin <= signalLoss ^ resetCtrl[RC_LOSS_POL];
      lockLostPin   <= lockIndicationStyle ? stickyLockLost : lockLost;
    end
  end
endmodule

/* File: cdr_regs_pkg.sv */
// Constants for the clock and data recovery control and status register bank
// Function
// - Status bit 5 reads 1 while input signal is lost.
// - Status bit 4 reads 0 when locked, 1 during frequency acquisition.
// - Status bit 3 reads 1 once signal-loss action finished, else 0.
// - Status bit 2 is sticky lock loss, held until software clears it.
// - Status bit 0 sets on rate measurement completion, held until cleared.
// - Mode field 001 locks to data, 011 to reference; 000, 010 reserved.
// - Writing 1 to first control bit 2 clears sticky lock loss.
// - Writing 1 to first control bit 1 starts fine rate measurement.
// - Writing 1 to first control bit 0 clears rate result and completion.
// - Writing 1 then 0 to second control bit 7 resets device.
// - Writing 1 then 0 to second control bit 6 restarts acquisition.
// - Second control bit 5 reserved zero; recovery always enabled.
// - Second control bit 3 set powers down signal-loss detector.
// - Second control bit 2 selects loss pin polarity: 0 high, 1 low.
// - Third control bit 2 at 0 enables reference clock; 1 powers down.
// - Reference-mode bit 6 picks lock check: 0 reference, 1 data.
// - Band field bits 5:4 picks reference band, 00 default lowest.
// - Ratio field bits 3:0 encodes ratio two to the (code minus one).
package cdr_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_STATUS      = 8'h06;
  localparam logic [7:0] OFS_MODE_CTRL   = 8'h08;
  localparam logic [7:0] OFS_RESET_CTRL  = 8'h09;
  localparam logic [7:0] OFS_REFPWR_CTRL = 8'h0a;
  localparam logic [7:0] OFS_REF_SETUP   = 8'h0f;
  localparam logic [7:0] OFS_SIG_HIGH    = 8'h20;
  localparam logic [7:0] OFS_SIG_LOW     = 8'h21;
  localparam logic [7:0] OFS_CAPTURE0    = 8'h42;
  localparam logic [7:0] OFS_CAPTURE1    = 8'h43;
  localparam logic [7:0] OFS_CAPTURE2    = 8'h44;
  localparam logic [7:0] OFS_CAPTURE3    = 8'h45;
  localparam logic [7:0] OFS_REVISION    = 8'h48;
  localparam logic [7:0] OFS_DEVICE      = 8'h49;

  // Status fields
  localparam int ST_SIGNAL_LOSS = 5;
  localparam int ST_LOCK_LOST   = 4;
  localparam int ST_LOSS_DONE   = 3;
  localparam int ST_STICKY_LOCK = 2;
  localparam int ST_RATE_DONE   = 0;

  // First control register fields
  localparam int MC_MODE_LSB    = 4;
  localparam int MC_STICKY_CLR  = 2;
  localparam int MC_RATE_START  = 1;
  localparam int MC_RATE_CLEAR  = 0;
  localparam logic [7:0] MC_WRITE_MASK = 8'h70;

  // Second control register fields
  localparam int RC_SOFT_RESET  = 7;
  localparam int RC_ACQ_START   = 6;
  localparam int RC_LOCK_STYLE  = 4;
  localparam int RC_LOSS_PDN    = 3;
  localparam int RC_LOSS_POL    = 2;
  localparam logic [7:0] RC_WRITE_MASK = 8'hdc;

  // Third control register fields
  localparam int PC_REF_PDN     = 2;
  localparam logic [7:0] PC_WRITE_MASK = 8'h04;

  // Reference-mode setup fields
  localparam int RS_CHECK_SRC   = 6;
  localparam int RS_BAND_LSB    = 4;
  localparam int RS_RATIO_LSB   = 0;
  localparam logic [7:0] RS_WRITE_MASK = 8'h7f;

  // Reset values
  localparam logic [7:0] RST_MODE_CTRL   = 8'h00;
  localparam logic [7:0] RST_RESET_CTRL  = 8'h00;
  localparam logic [7:0] RST_REFPWR_CTRL = 8'h04;
  localparam logic [7:0] RST_REF_SETUP   = 8'h00;

  // Recovery modes
  localparam logic [2:0] MODE_LOCK_DATA = 3'h1;
  localparam logic [2:0] MODE_LOCK_REF  = 3'h3;

  // Soft reset pulse held for this many cycles
  localparam int SOFT_RESET_NS     = 40;
  localparam int CLOCK_PERIOD_PS   = 4000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
endpackage

/* File: cdr_regs_sva.sv */
// Port assertions for the control and status register bank
`timescale 1ns/1ps
module cdr_regs_sva (
  // Clock, reset and register writes
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  // Controls to the core
  input wire logic [2:0] recoveryModeSelect,
  input wire logic       rateMeasureStart,
  input wire logic       rateMeasureClear,
  input wire logic       softResetPulse,
  input wire logic       frequencyAcquireStart,
  input wire logic       lockIndicationStyle,
  input wire logic       signalLossPowerDown,
  input wire logic       refClockPowerDown,
  input wire logic       lockCheckSource,
  input wire logic [1:0] refFreqBand,
  input wire logic [3:0] rateRatioCode,
  input wire logic       clockRecoveryEnable
);
  import cdr_regs_pkg::*;

  // Cycles the soft reset pulse has already stood; counted, not unrolled
  logic [7:0] pulseCycles;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulseCycles <= 8'h00;
    end else if (softResetPulse) begin
      pulseCycles <= pulseCycles + 8'h01;
    end else begin
      pulseCycles <= 8'h00;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_mode_write:
    assert property (regWrite && regAddr == 8'h08 && !softResetPulse |=> recoveryModeSelect == $past(regWdata[6:4]))
    else $error("mode field not taken");
  a_rate_pulses:
    assert property (regWrite && regAddr == 8'h08 && !softResetPulse |=> rateMeasureStart == $past(regWdata[1])
      && rateMeasureClear == $past(regWdata[0])) else $error("rate pulse wrong");
  a_reset_length:
    assert property (softResetPulse |-> pulseCycles < 8'(SOFT_RESET_CYCLES)) else $error("soft reset too long");
  a_reset_full:
    assert property ($fell(softResetPulse) |-> pulseCycles == 8'(SOFT_RESET_CYCLES)) else $error("soft reset too short");
  a_reset_cause:
    assert property ($rose(softResetPulse) |-> $past(regWrite && regAddr == 8'h09 && !regWdata[7]))
    else $error("soft reset without trigger");
  a_reset_reload:
    assert property (softResetPulse |=> refClockPowerDown && recoveryModeSelect == 3'h0) else $error("no reload");
  a_acquire_cause:
    assert property (frequencyAcquireStart |-> $past(regWrite && regAddr == 8'h09 && !regWdata[6]))
    else $error("acquire without trigger");
  a_recovery_on:
    assert property (clockRecoveryEnable) else $error("recovery disabled");
  a_loss_ctrl:
    assert property (regWrite && regAddr == 8'h09 && !softResetPulse |=> {lockIndicationStyle, signalLossPowerDown}
      == $past(regWdata[4:3])) else $error("loss control not taken");
  a_ref_power:
    assert property (regWrite && regAddr == 8'h0a && !softResetPulse |=> refClockPowerDown == $past(regWdata[2]))
    else $error("ref power not taken");
  a_ref_setup:
    assert property (regWrite && regAddr == 8'h0f && !softResetPulse |=> {lockCheckSource, refFreqBand, rateRatioCode}
      == $past(regWdata[6:0])) else $error("ref setup not taken");
endmodule

/* File: cdr_core_model.sv */
// Behavioural model of the recovery core behind the register bank
`timescale 1ns/1ps
module cdr_core_model (
  // Clock, reset and bank controls
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        rateMeasureStart,
  input  wire logic        rateMeasureClear,
  input  wire logic        frequencyAcquireStart,
  // Conditions set by the bench
  input  wire logic        lossIn,
  input  wire logic        lockLostIn,
  input  wire logic        actionDoneIn,
  // Core status
  output logic             signalLossRaw,
  output logic             lockLostRaw,
  output logic             lossActionDoneRaw,
  output logic             rateMeasureDone,
  output logic [31:0]      patternCaptureWord
);
  logic [3:0] measureCount;
  logic [3:0] acquireCount;
  assign signalLossRaw = lossIn;
  assign lossActionDoneRaw = actionDoneIn;
  // Lock is lost for the whole acquisition
  assign lockLostRaw = lockLostIn | (acquireCount != 4'h0);
  assign rateMeasureDone = (measureCount == 4'h1);
  assign patternCaptureWord = 32'h89abcdef;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      measureCount <= 4'h0;
      acquireCount <= 4'h0;
    end else begin
      // A clear abandons a measurement still running
      measureCount <= rateMeasureClear ? 4'h0 : rateMeasureStart ? 4'h6 : measureCount - {3'h0, measureCount != 4'h0};
      acquireCount <= frequencyAcquireStart ? 4'h8 : acquireCount - {3'h0, acquireCount != 4'h0};
    end
  end
endmodule

/* File: cdr_control_status_registers_bench.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
module cdr_control_status_registers_bench;
  import cdr_regs_pkg::*;
  localparam logic [7:0] REV_V = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEV_V = 8'h7d; // Arbitrary value
  localparam logic [7:0] SHI_V = 8'h11; // Arbitrary value
  localparam logic [7:0] SLO_V = 8'h22; // Arbitrary value
  logic        clock, rstn, regWrite, regRead, lossIn, lockLostIn, actionDoneIn;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic        signalLossRaw, lockLostRaw, lossActionDoneRaw, rateMeasureDone;
  logic [31:0] patternCaptureWord;
  logic [2:0]  recoveryModeSelect;
  logic        rateMeasureStart, rateMeasureClear, softResetPulse, frequencyAcquireStart, lockIndicationStyle;
  logic        signalLossPowerDown, refClockPowerDown, lockCheckSource, clockRecoveryEnable, signalLossPin, lockLostPin;
  logic [1:0]  refFreqBand;
  logic [3:0]  rateRatioCode;
  int          badCount, checksDone, i;
  cdr_control_status_registers #(.REVISION_VALUE(REV_V), .DEVICE_VALUE(DEV_V), .SIG_HIGH_VALUE(SHI_V),
    .SIG_LOW_VALUE(SLO_V)) uut (.*);
  cdr_core_model core (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop();
    $display("Checks %0d, mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic waitEnd(input logic stuck);
    chk({7'h0, stuck}, 8'h00);
    if (stuck) reportAndStop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    chk(regRdata, exp);
  endtask
  // Synchroniser plus status flop latency
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    {rstn, regWrite, regRead, lossIn, lockLostIn, actionDoneIn, regAddr, regWdata} = '0;
    repeat (2) @(posedge clock);
    #1;
    rstn = 1'b1;
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h04);
    rd(8'h0f, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h48, 8'hff);
    rd(8'h48, REV_V);
    rd(8'h49, DEV_V);
    rd(8'h20, SHI_V);
    rd(8'h21, SLO_V);
    for (i = 0; i < 4; i++) rd(8'h42 + i[7:0], patternCaptureWord[8*i +: 8]);
    rd(8'h07, 8'h00);
    wr(8'h08, 8'h98);
    rd(8'h08, 8'h10);
    wr(8'h08, 8'h30);
    rd(8'h08, 8'h30);
    wr(8'h0f, 8'hfa);
    rd(8'h0f, 8'h7a);
    wr(8'h0a, 8'hfb);
    rd(8'h0a, 8'h00);
    wr(8'h08, 8'h12);
    chk({7'h0, rateMeasureStart}, 8'h01);
    for (i = 0; i < 20 && !rateMeasureDone; i++) begin
      @(posedge clock);
      #1;
    end
    waitEnd(!rateMeasureDone);
    rd(8'h06, 8'h01);
    rd(8'h06, 8'h01);
    wr(8'h08, 8'h11);
    chk({7'h0, rateMeasureClear}, 8'h01);
    rd(8'h06, 8'h00);
    lossIn = 1'b1;
    actionDoneIn = 1'b1;
    settle();
    rd(8'h06, 8'h28);
    chk({7'h0, signalLossPin}, 8'h01);
    wr(8'h09, 8'h04);
    rd(8'h09, 8'h04);
    chk({7'h0, signalLossPin}, 8'h00);
    wr(8'h09, 8'h08);
    settle();
    rd(8'h06, 8'h08);
    lockLostIn = 1'b1;
    settle();
    rd(8'h06, 8'h1c);
    chk({7'h0, lockLostPin}, 8'h01);
    lockLostIn = 1'b0;
    settle();
    rd(8'h06, 8'h0c);
    chk({7'h0, lockLostPin}, 8'h00);
    wr(8'h09, 8'h18);
    rd(8'h09, 8'h18);
    chk({7'h0, lockLostPin}, 8'h01);
    wr(8'h08, 8'h14);
    rd(8'h06, 8'h08);
    wr(8'h09, 8'h40);
    wr(8'h09, 8'h00);
    chk({7'h0, frequencyAcquireStart}, 8'h01);
    settle();
    settle();
    rd(8'h06, 8'h2c);
    wr(8'h09, 8'h80);
    wr(8'h09, 8'h00);
    chk({7'h0, softResetPulse}, 8'h01);
    wr(8'h0f, 8'h01);
    for (i = 0; i < 20 && softResetPulse; i++) begin
      @(posedge clock);
      #1;
    end
    waitEnd(softResetPulse);
    rd(8'h0f, 8'h00);
    rd(8'h0a, 8'h04);
    rd(8'h08, 8'h00);
    rd(8'h06, 8'h28);
    reportAndStop();
  end
endmodule
bind cdr_control_status_registers cdr_regs_sva chk (.*);
